// ### rtl/msp_map.svh
`ifndef MSP_MAP_SVH
`define MSP_MAP_SVH

// Parameter numbers
`define MSP_PAR_START5_PEAK        8'h21
`define MSP_PAR_SPEED              8'h22
`define MSP_PAR_VOLT_DIST_A        8'h23
`define MSP_PAR_VOLT_DIST_B        8'h24
`define MSP_PAR_VOLT_DIST_C        8'h25
`define MSP_PAR_VOLT_DIST_MEAN     8'h26
`define MSP_PAR_CURR_DIST_A        8'h27
`define MSP_PAR_CURR_DIST_B        8'h28
`define MSP_PAR_CURR_DIST_C        8'h29
`define MSP_PAR_CURR_DIST_MEAN     8'h2A
`define MSP_PAR_STATUS             8'h2B
`define MSP_PAR_CONN_SELECT        8'h2C
`define MSP_PAR_CONN_USED          8'h2D

// Value ranges
`define MSP_PEAK_MAX               16'h3A98
`define MSP_SPEED_MAX              16'h0064
`define MSP_DIST_MAX               16'h03E8
`define MSP_CONN_SEL_MAX           16'h0002

// Reset values
`define MSP_CONN_SEL_RESET         2'h2
`define MSP_STATUS_RESET           16'h0000

// Status word bit positions
`define MSP_ST_READY               0
`define MSP_ST_POWER               1
`define MSP_ST_PHASE_ABC           2
`define MSP_ST_PHASE_VALID         3
`define MSP_ST_STARTING            4
`define MSP_ST_STOPPING            5
`define MSP_ST_ALARM               6
`define MSP_ST_FAULT               7
`define MSP_ST_AT_SPEED            8
`define MSP_ST_START_CONT          9
`define MSP_ST_BYPASS_CONT         10
`define MSP_ST_START_OK            11
`define MSP_ST_RSVD_LO             12
`define MSP_ST_RSVD_HI             13
`define MSP_ST_INPUT1              14
`define MSP_ST_INPUT2              15

`endif

// ### rtl/msp_pkg.sv
`default_nettype none
package msp_pkg;

    // Connection selections and connections in use
    typedef enum logic [1:0] {
        CONN_LINE  = 2'h0,
        CONN_DELTA = 2'h1,
        CONN_AUTO  = 2'h2
    } msp_conn_t;

    // Readings delivered by the metering logic
    typedef struct packed {
        logic [15:0] startPeak;
        logic [15:0] speed;
        logic [15:0] voltDistA;
        logic [15:0] voltDistB;
        logic [15:0] voltDistC;
        logic [15:0] currDistA;
        logic [15:0] currDistB;
        logic [15:0] currDistC;
    } msp_meas_t;

    // Controller condition levels and events
    typedef struct packed {
        logic ready;
        logic powerApplied;
        logic phaseAbc;
        logic phaseValid;
        logic starting;
        logic stopping;
        logic coasting;
        logic jogging;
        logic alarm;
        logic faultEvent;
        logic faultClear;
        logic fullVoltage;
        logic startContactor;
        logic bypassContactor;
        logic input1Closed;
        logic input2Closed;
        logic linearSpeedMode;
        logic detectedDelta;
    } msp_cond_t;

    // Parameter access request
    typedef struct packed {
        logic        rdEn;
        logic        wrEn;
        logic [7:0]  paramNum;
        logic [15:0] wrData;
    } msp_req_t;

    // Complete block state
    typedef struct packed {
        logic [15:0] startPeak;
        logic [15:0] speed;
        logic [15:0] voltDistA;
        logic [15:0] voltDistB;
        logic [15:0] voltDistC;
        logic [15:0] voltDistMean;
        logic [15:0] currDistA;
        logic [15:0] currDistB;
        logic [15:0] currDistC;
        logic [15:0] currDistMean;
        logic [15:0] statusWord;
        logic        faultLatch;
        msp_conn_t   connSelect;
        logic        connUsed;
        logic [15:0] rdData;
        logic        rdValid;
        logic        wrAck;
        logic        accessError;
    } msp_state_t;

endpackage : msp_pkg
`default_nettype wire

// ### rtl/msp_param_bank.sv
// What this block does
// R1 - Read-only fifth previous start peak, 0..15000
// R2 - Speed 0..100, valid in linear modes
// R3 - Three read-only voltage distortion values, 0..1000
// R4 - Voltage distortion mean of three phases
// R5 - Three read-only current distortion values, 0..1000
// R6 - Current distortion mean of three phases
// R7 - Bit0 ready, bit1 power to motor
// R8 - Bit2 phase rotation, 1 means ABC
// R9 - Bit3 valid three-phase supply detected
// R10 - Bit4 starting, bit5 controlled stop only
// R11 - Bit6 alarm, bit7 fault until cleared
// R12 - Bit8 full voltage applied to motor
// R13 - Bit9 start contactor, bit10 bypass contactor
// R14 - Bit11 start accepted; zero when busy/faulted
// R15 - Bits 12 and 13 always zero
// R16 - Bits 14,15 mirror control inputs one, two
// R17 - Published status equals status parameter exactly
// R18 - Connection select writable 0..2, default auto
// R19 - Read-only connection in use, line/delta
// R20 - Ignore read-only writes, reject out-of-range; read-only writes are refused with an accessError pulse too
`timescale 1ns/10ps
`default_nettype none
`include "msp_map.svh"

module msp_param_bank (
    input  wire logic              ref_clk,          // 250 MHz clock
    input  wire logic              rst,              // Async reset, active high
    input  wire msp_pkg::msp_meas_t meas,            // Metering readings
    input  wire msp_pkg::msp_cond_t cond,            // Controller conditions
    input  wire msp_pkg::msp_req_t  req,             // Parameter access request
    output logic [15:0]            rdData,           // Read value
    output logic                   rdValid,          // Read answer pulse
    output logic                   wrAck,            // Write accepted pulse
    output logic                   accessError,      // Refused access pulse
    output logic [15:0]            networkStatus,    // Status word to network
    output logic [1:0]             connectionSelect, // Selected connection
    output logic                   connectionDelta   // Connection in use is delta
);

    msp_pkg::msp_state_t cur;
    msp_pkg::msp_state_t next_cur;

    // Saturate a reading to its documented maximum
    function automatic logic [15:0] clampTo(input logic [15:0] val, input logic [15:0] maxVal);
        clampTo = (val > maxVal) ? maxVal : val;
    endfunction : clampTo

    // Mean of three values; sum is widened so no carry is lost
    function automatic logic [15:0] meanOf3(input logic [15:0] a, input logic [15:0] b,
                                            input logic [15:0] c);
        logic [17:0] sum;
        sum = {2'h0, a} + {2'h0, b} + {2'h0, c};
        meanOf3 = 16'(sum / 18'h3);
    endfunction : meanOf3

    logic        paramKnown;
    logic        paramWritable;
    logic [15:0] readMux;
    logic [15:0] va;
    logic [15:0] vb;
    logic [15:0] vc;
    logic [15:0] ia;
    logic [15:0] ib;
    logic [15:0] ic;
    logic        faultNow;
    logic [15:0] st;

    // Clamped distortion inputs shared by the per-phase and mean values
    always_comb begin
        va = clampTo(meas.voltDistA, `MSP_DIST_MAX);
        vb = clampTo(meas.voltDistB, `MSP_DIST_MAX);
        vc = clampTo(meas.voltDistC, `MSP_DIST_MAX);
        ia = clampTo(meas.currDistA, `MSP_DIST_MAX);
        ib = clampTo(meas.currDistB, `MSP_DIST_MAX);
        ic = clampTo(meas.currDistC, `MSP_DIST_MAX);
    end

    // Read mux over the stored parameters
    always_comb begin
        paramKnown = 1'b1;
        unique case (req.paramNum)
            `MSP_PAR_START5_PEAK:    readMux = cur.startPeak;
            `MSP_PAR_SPEED:          readMux = cur.speed;
            `MSP_PAR_VOLT_DIST_A:    readMux = cur.voltDistA;
            `MSP_PAR_VOLT_DIST_B:    readMux = cur.voltDistB;
            `MSP_PAR_VOLT_DIST_C:    readMux = cur.voltDistC;
            `MSP_PAR_VOLT_DIST_MEAN: readMux = cur.voltDistMean;
            `MSP_PAR_CURR_DIST_A:    readMux = cur.currDistA;
            `MSP_PAR_CURR_DIST_B:    readMux = cur.currDistB;
            `MSP_PAR_CURR_DIST_C:    readMux = cur.currDistC;
            `MSP_PAR_CURR_DIST_MEAN: readMux = cur.currDistMean;
            `MSP_PAR_STATUS:         readMux = cur.statusWord;
            `MSP_PAR_CONN_SELECT:    readMux = {14'h0000, cur.connSelect};
            `MSP_PAR_CONN_USED:      readMux = {15'h0000, cur.connUsed};
            default: begin
                readMux    = 16'h0000;
                paramKnown = 1'b0;
            end
        endcase
        paramWritable = (req.paramNum == `MSP_PAR_CONN_SELECT);
    end

    // Status word assembly from current conditions
    always_comb begin
        // Event set wins over a clear in the same cycle
        faultNow = cond.faultEvent | (cur.faultLatch & ~cond.faultClear); // R11
        st = `MSP_STATUS_RESET;
        st[`MSP_ST_READY]       = cond.ready;                               // R7
        st[`MSP_ST_POWER]       = cond.powerApplied;                        // R7
        st[`MSP_ST_PHASE_ABC]   = cond.phaseAbc;                            // R8
        st[`MSP_ST_PHASE_VALID] = cond.phaseValid;                          // R9
        st[`MSP_ST_STARTING]    = cond.starting;                            // R10
        st[`MSP_ST_STOPPING]    = cond.stopping & ~cond.coasting;           // R10
        st[`MSP_ST_ALARM]       = cond.alarm;                               // R11
        st[`MSP_ST_FAULT]       = faultNow;                                 // R11
        st[`MSP_ST_AT_SPEED]    = cond.fullVoltage;                         // R12
        st[`MSP_ST_START_CONT]  = cond.startContactor;                      // R13
        st[`MSP_ST_BYPASS_CONT] = cond.bypassContactor;                     // R13
        // A stopping motor blocks a new start, coasting included
        st[`MSP_ST_START_OK]    = cond.ready & ~faultNow & ~cond.starting
                                  & ~cond.stopping & ~cond.jogging;         // R14
        st[`MSP_ST_RSVD_LO]     = 1'b0;                                     // R15
        st[`MSP_ST_RSVD_HI]     = 1'b0;                                     // R15
        st[`MSP_ST_INPUT1]      = cond.input1Closed;                        // R16
        st[`MSP_ST_INPUT2]      = cond.input2Closed;                        // R16
    end

    // Next-state computation for the whole bank
    always_comb begin
        next_cur = cur;
        next_cur.startPeak    = clampTo(meas.startPeak, `MSP_PEAK_MAX);     // R1
        // Speed is zero outside linear-speed manoeuvres so stale estimates never show
        if (cond.linearSpeedMode && (cond.starting || cond.stopping)) begin
            next_cur.speed = clampTo(meas.speed, `MSP_SPEED_MAX);           // R2
        end else begin
            next_cur.speed = 16'h0000;                                      // R2
        end
        next_cur.voltDistA    = va;                                         // R3
        next_cur.voltDistB    = vb;                                         // R3
        next_cur.voltDistC    = vc;                                         // R3
        next_cur.voltDistMean = meanOf3(va, vb, vc);                        // R4
        next_cur.currDistA    = ia;                                         // R5
        next_cur.currDistB    = ib;                                         // R5
        next_cur.currDistC    = ic;                                         // R5
        next_cur.currDistMean = meanOf3(ia, ib, ic);                        // R6
        next_cur.faultLatch   = faultNow;                                   // R11
        next_cur.statusWord   = st;                                         // R17

        // Access answers are one-cycle pulses
        next_cur.rdValid     = 1'b0;
        next_cur.wrAck       = 1'b0;
        next_cur.accessError = 1'b0;
        if (req.rdEn) begin
            next_cur.rdData      = readMux;
            next_cur.rdValid     = 1'b1;
            next_cur.accessError = ~paramKnown;
        end
        if (req.wrEn) begin
            if (paramWritable && (req.wrData <= `MSP_CONN_SEL_MAX)) begin
                next_cur.connSelect = msp_pkg::msp_conn_t'(req.wrData[1:0]); // R18
                next_cur.wrAck      = 1'b1;
            end else begin
                next_cur.accessError = 1'b1;                                // R20
            end
        end

        // Connection actually used; auto follows the detector
        unique case (next_cur.connSelect)
            msp_pkg::CONN_LINE:  next_cur.connUsed = 1'b0;                  // R19
            msp_pkg::CONN_DELTA: next_cur.connUsed = 1'b1;                  // R19
            msp_pkg::CONN_AUTO:  next_cur.connUsed = cond.detectedDelta;    // R18
            default:             next_cur.connUsed = cur.connUsed;
        endcase
    end

    // State register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cur            <= '0;
            cur.connSelect <= msp_pkg::msp_conn_t'(`MSP_CONN_SEL_RESET);    // R18
        end else begin
            cur <= next_cur;
        end
    end

    // Outputs straight from state flops; network and parameter share one register
    assign rdData           = cur.rdData;
    assign rdValid          = cur.rdValid;
    assign wrAck            = cur.wrAck;
    assign accessError      = cur.accessError;
    assign networkStatus    = cur.statusWord;                               // R17
    assign connectionSelect = cur.connSelect;
    assign connectionDelta  = cur.connUsed;

endmodule : msp_param_bank
`default_nettype wire

// ### verification/msp_param_bank_properties.sv
`timescale 1ns/10ps
`default_nettype none
module msp_param_bank_checker (
    input wire logic               ref_clk,          // Clock
    input wire logic               rst,              // Async reset
    input wire msp_pkg::msp_cond_t cond,             // Conditions
    input wire msp_pkg::msp_req_t  req,              // Access request
    input wire logic               wrAck,            // Write accepted
    input wire logic               accessError,      // Refused access
    input wire logic [15:0]        networkStatus,    // Published status
    input wire logic [1:0]         connectionSelect, // Stored selection
    input wire logic               connectionDelta   // Connection in use
);
    // One domain, so one clock and one reset for every property
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // Status word relations; $past guarded so reset-time inputs are not compared
    property p_rsvd; networkStatus[13:12] == 2'h0; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved status bits set");
    property p_inputs;
        !$past(rst) |-> networkStatus[15:14] == $past({cond.input2Closed, cond.input1Closed});
    endproperty
    a_inputs: assert property (p_inputs) else $error("input bits wrong");
    property p_phase; !$past(rst) |-> networkStatus[2] == $past(cond.phaseAbc); endproperty
    a_phase: assert property (p_phase) else $error("rotation bit wrong");
    property p_fault; cond.faultEvent |=> networkStatus[7]; endproperty
    a_fault: assert property (p_fault) else $error("fault not flagged");
    property p_start_ok;
        networkStatus[11] |-> !networkStatus[7] && !networkStatus[4] && !networkStatus[5];
    endproperty
    a_start_ok: assert property (p_start_ok) else $error("start accepted while busy");
    property p_coast; cond.stopping && cond.coasting |=> !networkStatus[5]; endproperty
    a_coast: assert property (p_coast) else $error("coast flagged as stop");

    // Access port relations
    property p_wr_ok;
        req.wrEn && req.paramNum == 8'h2C && req.wrData <= 16'h0002
            |=> wrAck && connectionSelect == $past(req.wrData[1:0]);
    endproperty
    a_wr_ok: assert property (p_wr_ok) else $error("selection write lost");
    property p_wr_bad;
        req.wrEn && (req.paramNum != 8'h2C || req.wrData > 16'h0002)
            |=> accessError && !wrAck && $stable(connectionSelect);
    endproperty
    a_wr_bad: assert property (p_wr_bad) else $error("bad write not refused");
    property p_conn;
        connectionSelect != 2'h2 |-> connectionDelta == connectionSelect[0];
    endproperty
    a_conn: assert property (p_conn) else $error("connection in use wrong");

    // Main scenarios reached
    c_write: cover property (req.wrEn ##1 wrAck);
    c_fault: cover property ($rose(networkStatus[7]));
    c_refused: cover property (accessError);
endmodule : msp_param_bank_checker
bind msp_param_bank msp_param_bank_checker u_chk (.ref_clk(ref_clk), .rst(rst), .cond(cond),
    .req(req), .wrAck(wrAck), .accessError(accessError), .networkStatus(networkStatus),
    .connectionSelect(connectionSelect), .connectionDelta(connectionDelta));
`default_nettype wire

// ### verification/msp_peer_model.sv
`timescale 1ns/10ps
`default_nettype none
module msp_peer_model (
    input  wire logic              ref_clk,    // Clock
    output var msp_pkg::msp_req_t  req,        // Request to the bank
    input  wire logic [15:0]       rdData,     // Read value
    input  wire logic              rdValid,    // Read answer
    input  wire logic              wrAck,      // Write accepted
    input  wire logic              accessError // Refused access
);
    // Idle until the first access
    initial req = '0;

    // Held across the taking edge; the answer is fixed at one cycle, no ready
    task automatic access(input logic rd, wr, input logic [7:0] num, input logic [15:0] d,
                          output logic [15:0] v, output logic [2:0] f);
        @(negedge ref_clk);
        req = '{rd, wr, num, d};
        @(negedge ref_clk);
        // Released lines show the inverse so a stale value cannot pass
        req = '{1'b0, 1'b0, ~num, ~d};
        v = rdData;
        f = {rdValid, wrAck, accessError};
    endtask : access
endmodule : msp_peer_model
`default_nettype wire

// ### verification/msp_param_bank_bench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin err_count++; \
    $display("unexpected %s exp %h got %h", n, e, a); end end
module msp_param_bank_bench;
    logic               ref_clk, rst, rdValid, wrAck, accessError, connectionDelta, fault;
    logic [15:0]        rdData, networkStatus;
    logic [1:0]         connectionSelect;
    msp_pkg::msp_meas_t meas;
    msp_pkg::msp_cond_t cond;
    msp_pkg::msp_req_t  req;
    int                 err_count, num_checks;

    msp_param_bank DUT (.ref_clk(ref_clk), .rst(rst), .meas(meas), .cond(cond), .req(req),
        .rdData(rdData), .rdValid(rdValid), .wrAck(wrAck), .accessError(accessError),
        .networkStatus(networkStatus), .connectionSelect(connectionSelect),
        .connectionDelta(connectionDelta));
    msp_peer_model PEER (.ref_clk(ref_clk), .req(req), .rdData(rdData), .rdValid(rdValid),
        .wrAck(wrAck), .accessError(accessError));

    // Clock of 4 ns
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // One access and its judged answer; flags are read, write, refused
    task automatic xfer(input logic rd, wr, input logic [7:0] num, input logic [15:0] d, expd,
                        input logic [2:0] expf, input string nm);
        logic [15:0] v;
        logic [2:0]  f;
        PEER.access(rd, wr, num, d, v, f);
        `CHK(nm, expf, f)
        if (rd) `CHK(nm, expd, v)
    endtask : xfer

    task automatic tally_and_finish;
        if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : tally_and_finish

    task automatic s_reset;
        `CHK("select", 2'h2, connectionSelect)
        xfer(1, 0, 8'h2C, 16'h0000, 16'h0002, 3'b100, "sel");
        xfer(1, 0, 8'h21, 16'h0000, 16'h0000, 3'b100, "peak");
    endtask : s_reset

    // Over-range readings clamp before the means are taken
    task automatic s_meas;
        logic [15:0] e [10] = '{16'h3A98, 16'h0064, 16'h03E8, 16'h03E7, 16'h0002, 16'h029B,
                                16'h03E8, 16'h0004, 16'h0006, 16'h0150};
        @(negedge ref_clk);
        meas = '{16'hFFFF, 16'h00C8, 16'h07D0, 16'h03E7, 16'h0002, 16'h8000, 16'h0004, 16'h0006};
        cond = 18'h02002;
        for (int i = 0; i < 10; i++) begin
            xfer(1, 0, 8'h21 + 8'(i), 16'h0000, e[i], 3'b100, "reading");
        end
        cond = 18'h02000;
        xfer(1, 0, 8'h22, 16'h0000, 16'h0000, 3'b100, "speed");
        xfer(0, 1, 8'h23, 16'h0001, 16'h0000, 3'b001, "ro write");
        xfer(1, 0, 8'h23, 16'h0000, 16'h03E8, 3'b100, "ro kept");
    endtask : s_meas

    // Each condition alone with ready, then stop/coast and the fault latch cases
    task automatic s_status;
        logic [17:0] ext [6] = '{18'h01800, 18'h00100, 18'h0, 18'h00180, 18'h0, 18'h00080};
        logic [15:0] e;
        for (int i = 0; i < 24; i++) begin
            @(negedge ref_clk);
            cond = (i < 18) ? (18'h20000 | (18'h20000 >> i)) : ext[i - 18];
            fault = cond.faultEvent | (fault & ~cond.faultClear);
            e = {cond.input2Closed, cond.input1Closed, 2'b00,
                 cond.ready & ~fault & ~cond.starting & ~cond.stopping & ~cond.jogging,
                 cond.bypassContactor, cond.startContactor, cond.fullVoltage, fault, cond.alarm,
                 cond.stopping & ~cond.coasting, cond.starting, cond.phaseValid, cond.phaseAbc,
                 cond.powerApplied, cond.ready};
            xfer(1, 0, 8'h2B, 16'h0000, e, 3'b100, "status read");
            `CHK("status", e, networkStatus)
        end
    endtask : s_status

    task automatic s_conn;
        xfer(0, 1, 8'h2C, 16'h0001, 16'h0000, 3'b010, "wr delta");
        `CHK("delta", 1'b1, connectionDelta)
        xfer(1, 0, 8'h2D, 16'h0000, 16'h0001, 3'b100, "in use");
        xfer(0, 1, 8'h2C, 16'h0000, 16'h0000, 3'b010, "wr line");
        `CHK("line", 1'b0, connectionDelta)
        xfer(0, 1, 8'h2C, 16'h0003, 16'h0000, 3'b001, "wr range");
        xfer(0, 1, 8'h2B, 16'h0001, 16'h0000, 3'b001, "wr ro");
        `CHK("kept", 2'h0, connectionSelect)
        cond.detectedDelta = 1'b1;
        xfer(0, 1, 8'h2C, 16'h0002, 16'h0000, 3'b010, "wr auto");
        `CHK("auto", 1'b1, connectionDelta)
        xfer(1, 0, 8'h40, 16'h0000, 16'h0000, 3'b101, "unmapped");
    endtask : s_conn

    // Reset in mid-run brings the selection back to auto from a written delta
    task automatic s_rerst;
        xfer(0, 1, 8'h2C, 16'h0001, 16'h0000, 3'b010, "wr pre-reset");
        rst = 1'b1;
        repeat (2) @(negedge ref_clk);
        `CHK("rst select", 2'h2, connectionSelect)
        `CHK("rst delta", 1'b0, connectionDelta)
        `CHK("rst status", 16'h0000, networkStatus)
        rst = 1'b0;
        @(negedge ref_clk);
        `CHK("auto after rst", 1'b1, connectionDelta)
        xfer(1, 0, 8'h2C, 16'h0000, 16'h0002, 3'b100, "sel after rst");
    endtask : s_rerst

    // Main sequence
    initial begin
        rst = 1'b1;
        meas = '0;
        cond = '0;
        fault = 1'b0;
        err_count = 0;
        num_checks = 0;
        repeat (20) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        s_reset;
        s_meas;
        s_status;
        s_conn;
        s_rerst;
        tally_and_finish;
    end

    // Whole run needs about 150 cycles
    initial begin
        repeat (5000) @(posedge ref_clk);
        err_count++;
        tally_and_finish;
    end
endmodule : msp_param_bank_bench
`default_nettype wire
